// ==== design/mmd_decoder.sv ====
// Summary of operation
// - each decode box owns a 16 KB window, local offsets 0x0000 to 0x3fff
// - unowned decode box offsets go to codec front end, reads zero
// - fixed offset ranges route to streamer, codec, av1, encode, config
// - box bases at 0x1c/0x1d/0x1e/0x1f groups: two decode, one enhance
// - slice id is group index; subslice 01 for odd decode boxes only
// - engine instance index spans zero through seven
// - high-efficiency codec decoded as separate front and back ranges
// - message endpoint unit never receives any mmio access
`timescale 1ns/10ps
`default_nettype none
module mmd_decoder
  import mmd_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // host fabric side
  input  wire mmd_req_s          host_req,
  output logic                   host_ready,
  output logic                   host_rvalid,
  output logic [DATA_W-1:0]      host_rdata,
  // engine unit side
  output mmd_tgt_s               unit_tgt,
  input  wire logic              unit_rvalid,
  input  wire logic [DATA_W-1:0] unit_rdata
);

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic in_rng(input logic [13:0] o,
                                  input logic [13:0] lo,
                                  input logic [13:0] hi);
    in_rng = (o >= lo) && (o <= hi);
  endfunction

  // ***********************************************************
  // address decode
  // ***********************************************************
  // every upper bit takes part, so no alias of the media space decodes
  wire logic [13:0]      tag_w   = host_req.addr[ADDR_W-1:TAG_LSB];
  wire logic [1:0]       grp_w   = host_req.addr[TAG_LSB-1:GRP_LSB];
  wire logic [1:0]       box_w   = host_req.addr[GRP_LSB-1:BOX_LSB];
  wire logic [OFS_W-1:0] ofs_w   = host_req.addr[OFS_W-1:0];
  wire logic             media_w = (tag_w == MEDIA_TAG);
  wire logic             vd_w    = media_w && !box_w[1];
  wire logic             ve_w    = media_w && (box_w == 2'h2);
  wire logic             hit_w   = vd_w || ve_w;
  // decode engines 0..7 are group*2 + odd bit
  wire logic [2:0]       eng_w   = vd_w ? {grp_w, box_w[0]}
                                        : {1'b0, grp_w};
  wire logic [2:0]       slc_w   = {1'b0, grp_w};
  wire logic [1:0]       sub_w   = (vd_w && box_w[0]) ? SUBSLICE_ODDV
                                                      : SUBSLICE_EVEN;

  // no select exists for the message endpoint unit
  mmd_unit_e vd_unit_w;
  always_comb begin
    if (in_rng(ofs_w, CS0_LO, CS0_HI)) begin
      vd_unit_w = MMD_U_CS0;
    end else if (in_rng(ofs_w, MFC_LO, MFC_HI)) begin
      vd_unit_w = MMD_U_MFC;
    end else if (in_rng(ofs_w, CS1_LO, CS1_HI)) begin
      vd_unit_w = MMD_U_CS1;
    end else if (in_rng(ofs_w, CWR_LO, CWR_HI)) begin
      vd_unit_w = MMD_U_CODEC_BE;
    end else if (in_rng(ofs_w, AV1_LO, AV1_HI)) begin
      vd_unit_w = MMD_U_AV1;
    end else if (in_rng(ofs_w, ENC_LO, ENC_HI)) begin
      vd_unit_w = MMD_U_ENC;
    end else if (in_rng(ofs_w, CFG_LO, CFG_HI)) begin
      vd_unit_w = MMD_U_CFG;
    end else begin
      // holes and the reserved range fall to the front end
      vd_unit_w = MMD_U_CODEC_FE;
    end
  end

  wire mmd_unit_e unit_w = vd_w ? vd_unit_w
                         : (ve_w ? MMD_U_ENHANCE : MMD_U_NONE);

  // ***********************************************************
  // request sequencing
  // ***********************************************************
  // one read outstanding at a time keeps answers in request order
  mmd_state_e state_q;
  mmd_state_e state_d;
  mmd_tgt_s   tgt_q;
  mmd_tgt_s   tgt_d;
  logic       rv_q;
  logic       rv_d;
  logic [DATA_W-1:0] rd_q;
  logic [DATA_W-1:0] rd_d;

  wire logic take_w  = host_req.valid && host_ready;
  wire logic miss_rd = take_w && !hit_w && !host_req.write;

  assign host_ready = (state_q == MMD_IDLE);

  always_comb begin
    tgt_d.valid       = take_w && hit_w;
    tgt_d.write       = host_req.write;
    tgt_d.unit        = unit_w;
    tgt_d.is_decode   = vd_w;
    tgt_d.engine      = eng_w;
    tgt_d.slice_id    = slc_w;
    tgt_d.subslice_id = sub_w;
    tgt_d.offset      = ofs_w;
    tgt_d.wdata       = host_req.wdata;
    state_d = state_q;
    case (state_q)
      MMD_IDLE: begin
        if (take_w && hit_w && !host_req.write) begin
          state_d = MMD_WAIT;
        end
      end
      MMD_WAIT: begin
        if (unit_rvalid) begin
          state_d = MMD_IDLE;
        end
      end
      default: state_d = MMD_IDLE;
    endcase
    rv_d = miss_rd || ((state_q == MMD_WAIT) && unit_rvalid);
    rd_d = ((state_q == MMD_WAIT) && unit_rvalid) ? unit_rdata
                                                  : READ_ZERO;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= MMD_IDLE;
      tgt_q   <= '0;
      rv_q    <= 1'b0;
      rd_q    <= READ_ZERO;
    end else begin
      state_q <= state_d;
      tgt_q   <= tgt_d;
      rv_q    <= rv_d;
      rd_q    <= rd_d;
    end
  end

  assign unit_tgt    = tgt_q;
  assign host_rvalid = rv_q;
  assign host_rdata  = rd_q;

  // ***********************************************************
  // checks
  // ***********************************************************
  a_decode_one_cycle: assert property (
    @(posedge mclk) disable iff (!rstn)
    take_w && hit_w |=> unit_tgt.valid
      && unit_tgt.offset == $past(host_req.addr[OFS_W-1:0]))
    else $error("decoded access not forwarded next cycle");
  a_window_base: assert property (
    @(posedge mclk) disable iff (!rstn)
    take_w && host_req.addr == 32'h001d_47ff |=> unit_tgt.is_decode
      && unit_tgt.engine == 3'h3 && unit_tgt.offset == 14'h07ff)
    else $error("decode box 3 window misplaced");
  a_enh_base: assert property (
    @(posedge mclk) disable iff (!rstn)
    take_w && host_req.addr == 32'h001e_8000 |=>
      unit_tgt.unit == MMD_U_ENHANCE && unit_tgt.slice_id == 3'h2)
    else $error("enhancement box 2 misplaced");
  a_hole_frontend: assert property (
    @(posedge mclk) disable iff (!rstn)
    take_w && vd_w && (ofs_w == 14'h2000 || ofs_w == 14'h3000) |=>
      unit_tgt.unit == MMD_U_CODEC_FE)
    else $error("hole not routed to codec front end");
  a_range_owner: assert property (
    @(posedge mclk) disable iff (!rstn)
    take_w && vd_w && ofs_w == 14'h2d00 |=>
      unit_tgt.unit == MMD_U_ENC)
    else $error("encode assist range misrouted");
  a_codec_split: assert property (
    @(posedge mclk) disable iff (!rstn)
    take_w && vd_w && ofs_w == 14'h2aff |=>
      unit_tgt.unit == MMD_U_CODEC_BE)
    else $error("codec back end range misrouted");
  a_subslice_id: assert property (
    @(posedge mclk) disable iff (!rstn)
    unit_tgt.valid |-> unit_tgt.subslice_id ==
      ((unit_tgt.is_decode && unit_tgt.engine[0]) ? 2'h1 : 2'h0))
    else $error("subslice id wrong");
  a_engine_range: assert property (
    @(posedge mclk) disable iff (!rstn)
    unit_tgt.valid && !unit_tgt.is_decode |-> unit_tgt.engine <= 3'h3
      && unit_tgt.unit == MMD_U_ENHANCE)
    else $error("enhancement engine index out of range");
  a_no_endpoint: assert property (
    @(posedge mclk) disable iff (!rstn)
    unit_tgt.valid |-> unit_tgt.unit != MMD_U_NONE
      && unit_tgt.unit <= MMD_U_ENHANCE)
    else $error("access routed to unit without window");
  a_miss_zero: assert property (
    @(posedge mclk) disable iff (!rstn)
    miss_rd |=> host_rvalid && host_rdata == 32'h0 && !unit_tgt.valid)
    else $error("unclaimed read not answered with zero");
  // a waiting read must neither forward nor answer anything else
  a_read_order: assert property (
    @(posedge mclk) disable iff (!rstn)
    state_q == MMD_WAIT && !unit_rvalid |=> !host_rvalid
      && !unit_tgt.valid && !host_ready)
    else $error("request served while read outstanding");
  // the unit's word must reach the host untouched, one cycle later
  a_answer_data: assert property (
    @(posedge mclk) disable iff (!rstn)
    state_q == MMD_WAIT && unit_rvalid |=> host_rvalid && host_ready
      && host_rdata == $past(unit_rdata))
    else $error("unit answer not returned next cycle");
  a_write_silent: assert property (
    @(posedge mclk) disable iff (!rstn)
    take_w && host_req.write |=> !host_rvalid && host_ready)
    else $error("write produced a read answer");

  // ***********************************************************
  // cover points
  // ***********************************************************

  c_vd_read: cover property (@(posedge mclk) disable iff (!rstn)
    take_w && vd_w && !host_req.write ##[1:20] host_rvalid);
  c_ve_write: cover property (@(posedge mclk) disable iff (!rstn)
    take_w && ve_w && host_req.write);
  c_miss_read: cover property (@(posedge mclk) disable iff (!rstn)
    miss_rd);
  c_hole_read: cover property (@(posedge mclk) disable iff (!rstn)
    take_w && vd_w && vd_unit_w == MMD_U_CODEC_FE);

endmodule
`default_nettype wire

// ==== design/mmd_pkg.sv ====
`default_nettype none
package mmd_pkg;

  // ***********************************************************
  // address map
  // ***********************************************************
  localparam int          ADDR_W        = 32;
  localparam int          DATA_W        = 32;
  localparam int          OFS_W         = 14;
  localparam logic [31:0] WIN_SIZE      = 32'h0000_4000;
  localparam logic [31:0] MEDIA_BASE    = 32'h001c_0000;
  localparam logic [31:0] VD_EVEN_OFS   = 32'h0000_0000;
  localparam logic [31:0] VD_ODD_OFS    = 32'h0000_4000;
  localparam logic [31:0] VE_OFS        = 32'h0000_8000;
  localparam logic [13:0] MEDIA_TAG     = 14'h0007;
  localparam int          TAG_LSB       = 18;
  localparam int          GRP_LSB       = 16;
  localparam int          BOX_LSB       = 14;
  localparam int          MAX_ENGINE    = 7;

  // ***********************************************************
  // sub-range limits inside a decode box window
  // ***********************************************************
  localparam logic [13:0] CS0_LO  = 14'h0000;
  localparam logic [13:0] CS0_HI  = 14'h07ff;
  localparam logic [13:0] MFC_LO  = 14'h0800;
  localparam logic [13:0] MFC_HI  = 14'h0fff;
  localparam logic [13:0] CS1_LO  = 14'h1000;
  localparam logic [13:0] CS1_HI  = 14'h1fff;
  localparam logic [13:0] CWR_LO  = 14'h2800;
  localparam logic [13:0] CWR_HI  = 14'h2aff;
  localparam logic [13:0] AV1_LO  = 14'h2b00;
  localparam logic [13:0] AV1_HI  = 14'h2cff;
  localparam logic [13:0] ENC_LO  = 14'h2d00;
  localparam logic [13:0] ENC_HI  = 14'h2dff;
  localparam logic [13:0] RSV_LO  = 14'h2e00;
  localparam logic [13:0] RSV_HI  = 14'h3eff;
  localparam logic [13:0] CFG_LO  = 14'h3f00;
  localparam logic [13:0] CFG_HI  = 14'h3fff;

  localparam logic [2:0]  SUBSLICE_ODD  = 3'h1;
  localparam logic [1:0]  SUBSLICE_EVEN = 2'h0;
  localparam logic [1:0]  SUBSLICE_ODDV = 2'h1;
  localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [3:0] {
    MMD_U_NONE       = 4'h0,
    MMD_U_CS0        = 4'h1,
    MMD_U_MFC        = 4'h2,
    MMD_U_CS1        = 4'h3,
    MMD_U_CODEC_BE   = 4'h4,
    MMD_U_AV1        = 4'h5,
    MMD_U_ENC        = 4'h6,
    MMD_U_CFG        = 4'h7,
    MMD_U_CODEC_FE   = 4'h8,
    MMD_U_ENHANCE    = 4'h9
  } mmd_unit_e;

  typedef enum logic [1:0] {
    MMD_IDLE = 2'b00,
    MMD_WAIT = 2'b01
  } mmd_state_e;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mmd_req_s;

  typedef struct packed {
    logic              valid;
    logic              write;
    mmd_unit_e         unit;
    logic              is_decode;
    logic [2:0]        engine;
    logic [2:0]        slice_id;
    logic [1:0]        subslice_id;
    logic [OFS_W-1:0]  offset;
    logic [DATA_W-1:0] wdata;
  } mmd_tgt_s;

endpackage
`default_nettype wire

// ==== bench/mmd_unit_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ***********************************************************
// engine units behind the decoder: answer reads after lat edges
// ***********************************************************
module mmd_unit_model
  import mmd_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // decoder side
  input  wire mmd_tgt_s          tgt,
  input  wire logic [3:0]        lat,
  output logic                   rvalid,
  output logic [DATA_W-1:0]      rdata
);
  logic [3:0]        cnt_q;
  logic              pend_q;
  logic [DATA_W-1:0] val_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= 4'h0;
      pend_q <= 1'b0;
      val_q  <= 32'h0000_0000;
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
    end else begin
      rvalid <= 1'b0;
      // stale data toggles so it never passes for an answer
      rdata  <= ~rdata;
      if (tgt.valid && !tgt.write) begin
        pend_q <= 1'b1;
        cnt_q  <= lat;
        // front end reads back zero, others echo their routing
        val_q  <= (tgt.unit == MMD_U_CODEC_FE) ? READ_ZERO :
                  {tgt.unit, tgt.engine, tgt.slice_id, tgt.subslice_id,
                   6'h00, tgt.offset};
      end else if (pend_q) begin
        if (cnt_q <= 4'h1) begin
          rvalid <= 1'b1;
          rdata  <= val_q;
          pend_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb_mmd_decoder.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t %s", $time, m); end end
module tb_mmd_decoder;
  import mmd_pkg::*;
  // ***********************************************************
  // harness
  // ***********************************************************
  logic              mclk;
  logic              rstn;
  mmd_req_s          host_req;
  logic              host_ready;
  logic              host_rvalid;
  logic [DATA_W-1:0] host_rdata;
  mmd_tgt_s          unit_tgt;
  logic              unit_rvalid;
  logic [DATA_W-1:0] unit_rdata;
  logic [3:0]        lat;
  int                failures = 0;
  int                n_tests = 0;
  int                cycles = 0;
  logic [13:0]       offs [18] = '{14'h0000, 14'h07ff, 14'h0800, 14'h0fff,
    14'h1000, 14'h1ffc, 14'h2000, 14'h27ff, 14'h2800, 14'h2aff, 14'h2b00,
    14'h2cff, 14'h2d00, 14'h2dff, 14'h2e00, 14'h3eff, 14'h3f00, 14'h3fff};
  logic [31:0]       miss [6] = '{32'h001c_c000, 32'h001f_fffc,
    32'h001b_fffc, 32'h0020_0000, 32'h801c_0000, 32'h0000_0000};

  mmd_decoder dut (.mclk(mclk), .rstn(rstn), .host_req(host_req),
    .host_ready(host_ready), .host_rvalid(host_rvalid),
    .host_rdata(host_rdata), .unit_tgt(unit_tgt),
    .unit_rvalid(unit_rvalid), .unit_rdata(unit_rdata));
  mmd_unit_model units (.mclk(mclk), .rstn(rstn), .tgt(unit_tgt),
    .lat(lat), .rvalid(unit_rvalid), .rdata(unit_rdata));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // a hung handshake must still reach the verdict
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic mmd_unit_e eu(logic [13:0] o, logic [1:0] s);
    if (s == 2'h2) return MMD_U_ENHANCE;
    if (o <= CS0_HI) return MMD_U_CS0;
    if (o <= MFC_HI) return MMD_U_MFC;
    if (o <= CS1_HI) return MMD_U_CS1;
    if (o < CWR_LO) return MMD_U_CODEC_FE;
    if (o <= CWR_HI) return MMD_U_CODEC_BE;
    if (o <= AV1_HI) return MMD_U_AV1;
    if (o <= ENC_HI) return MMD_U_ENC;
    if (o < CFG_LO) return MMD_U_CODEC_FE;
    return MMD_U_CFG;
  endfunction
  // ***********************************************************
  // host accesses; valid stays up so writes run back to back
  // ***********************************************************
  task automatic go(input logic w, input logic [31:0] a,
                    output mmd_tgt_s t, output logic [31:0] rd,
                    output int n);
    @(negedge mclk);
    host_req = '{1'b1, w, a, ~a};
    @(posedge mclk);
    #1 t = unit_tgt;
    n = 0;
    while (!w && host_rvalid !== 1'b1 && n < 30) begin
      `CHK(host_ready, 1'b0, "ready while read open")
      @(posedge mclk);
      #1 n++;
    end
    rd = host_rdata;
  endtask

  task automatic chk_hit(input logic w, input logic [31:0] a);
    mmd_tgt_s    t;
    logic [31:0] rd;
    logic [31:0] x;
    int          n;
    logic [1:0]  s;
    logic [2:0]  e;
    logic [1:0]  ss;
    mmd_unit_e   u;
    s  = a[15:14];
    u  = eu(a[13:0], s);
    e  = (s == 2'h2) ? {1'b0, a[17:16]} : {a[17:16], s[0]};
    ss = (s == 2'h1) ? 2'h1 : 2'h0;
    x  = {u, e, 1'b0, a[17:16], ss, 6'h00, a[13:0]};
    go(w, a, t, rd, n);
    `CHK(t.valid, 1'b1, "box missed")
    `CHK(t.write, w, "write flag")
    `CHK(t.is_decode, s != 2'h2, "box kind")
    `CHK(t.unit, u, "wrong unit")
    `CHK(t.offset, a[13:0], "offset")
    `CHK(t.slice_id, {1'b0, a[17:16]}, "slice id")
    `CHK(t.subslice_id, ss, "subslice id")
    `CHK(t.engine, e, "engine index")
    if (w) `CHK(t.wdata, ~a, "write data")
    else `CHK(rd, (u == MMD_U_CODEC_FE) ? READ_ZERO : x, "read data")
  endtask

  task automatic chk_miss(input logic w, input logic [31:0] a);
    mmd_tgt_s    t;
    logic [31:0] rd;
    int          n;
    go(w, a, t, rd, n);
    `CHK(t.valid, 1'b0, "stray route")
    if (!w) begin
      `CHK(n, 0, "late zero answer")
      `CHK(rd, READ_ZERO, "unclaimed data")
    end
  endtask
  // ***********************************************************
  // scenarios
  // ***********************************************************
  task automatic t_map;
    for (int g = 0; g < 4; g++)
      for (int s = 0; s < 3; s++)
        for (int i = 0; i < 18; i++)
          chk_hit(1'b0, MEDIA_BASE + 32'(g * 32'h1_0000 + s * 32'h4000)
                  + 32'(offs[i]));
  endtask

  task automatic t_write;
    for (int i = 0; i < 18; i++)
      chk_hit(1'b1, MEDIA_BASE + 32'((i % 4) * 32'h1_0000)
              + 32'((i % 3) * 32'h4000) + 32'(offs[i]));
  endtask

  task automatic t_miss;
    for (int i = 0; i < 6; i++) begin
      chk_miss(1'b0, miss[i]);
      chk_miss(1'b1, miss[i]);
    end
    chk_hit(1'b0, 32'h001d_7f00);
  endtask

  // slow units: the host must stay blocked the whole wait
  task automatic t_slow;
    lat = 4'h9;
    chk_hit(1'b0, 32'h001f_5000);
    chk_hit(1'b0, 32'h001e_2e00);
    lat = 4'h1;
  endtask

  task automatic t_reset;
    @(negedge mclk);
    host_req = '{1'b1, 1'b0, 32'h001c_0810, 32'h0000_0000};
    @(negedge mclk);
    host_req.valid = 1'b0;
    rstn = 1'b0;
    #1 `CHK(host_ready, 1'b1, "ready in reset")
    `CHK(host_rvalid, 1'b0, "answer in reset")
    `CHK(unit_tgt.valid, 1'b0, "route in reset")
    @(negedge mclk);
    rstn = 1'b1;
    chk_hit(1'b0, 32'h001c_8004);
  endtask

  initial begin
    rstn = 1'b0;
    host_req = '0;
    lat = 4'h1;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    t_map();
    t_write();
    t_miss();
    t_slow();
    t_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
